//--- hw/fpp_ctrl.sv
/*
 * fpp_ctrl: flash array with word programming, block erase, per-block
 * protection, clock-based op timing, user registers and commits.
 * Assumes an AXI4-Lite master and a fetch/read port from the core.
 * nv_init_n models the factory state of the non-volatile cells only.
 */
// Overview of operation
// - programming stores new word ANDed with old contents
// - one protection state per 2 kB block, three possible states
// - full-access blocks allow read, fetch, erase and program
// - no-modify blocks allow read and fetch, refuse erase and program
// - fetch-only blocks answer fetches only, deny data reads
// - protection may only tighten; fetch-only is frozen
// - loosening attempts are blocked, unchanged and reported failed
// - uncommitted protection reverts to committed values at reset
// - protection commit keeps settings through any reset
// - protection violations raise the access violation flag
// - program timing comes from the clocks per microsecond value
// - clocks per microsecond does not affect reads, reads back
// - two user registers, writable and readable
// - user commit keeps both user values through any reset
// - a programming error reports a failure status
// - bad block address or protection code fails and changes nothing
// - erase sets every bit of one 1 kB block to one
// - finished erase or program sets the done flag
// - per-source enables gate the interrupt; raw and masked readable
// - writing ones clears selected interrupt flags
module fpp_ctrl
   import fpp_pkg::*;
#(
   parameter int FLASH_WORDS = 1024
)(
   input  wire logic        aclk,          // system clock
   input  wire logic        aresetn,       // sync reset, active low
   input  wire logic        nv_init_n,     // factory init of nv cells
   input  wire logic [31:0] s_axi_awaddr,  // write address
   input  wire logic        s_axi_awvalid, // write address valid
   output logic             s_axi_awready, // write address ready
   input  wire logic [31:0] s_axi_wdata,   // write data
   input  wire logic [3:0]  s_axi_wstrb,   // write strobes
   input  wire logic        s_axi_wvalid,  // write data valid
   output logic             s_axi_wready,  // write data ready
   output logic [1:0]       s_axi_bresp,   // write response
   output logic             s_axi_bvalid,  // write response valid
   input  wire logic        s_axi_bready,  // write response ready
   input  wire logic [31:0] s_axi_araddr,  // read address
   input  wire logic        s_axi_arvalid, // read address valid
   output logic             s_axi_arready, // read address ready
   output logic [31:0]      s_axi_rdata,   // read data
   output logic [1:0]       s_axi_rresp,   // read response
   output logic             s_axi_rvalid,  // read data valid
   input  wire logic        s_axi_rready,  // read data ready
   input  wire logic        acc_valid,     // core flash access
   input  wire logic        acc_fetch,     // 1 fetch, 0 data read
   input  wire logic [31:0] acc_addr,      // access byte address
   output logic [31:0]      acc_rdata,     // read data
   output logic             acc_denied,    // access refused
   output logic             flash_irq      // masked interrupt
);
   localparam int WA  = $clog2(FLASH_WORDS);
   localparam int NPB = FLASH_WORDS * 4 / PROT_BYTES;
   localparam int PA  = (NPB > 1) ? $clog2(NPB) : 1;
   localparam int EA  = $clog2(ERASE_BYTES);
   localparam int BA  = $clog2(PROT_BYTES);
   localparam logic [31:0] FLASH_BYTES = 32'(FLASH_WORDS * 4);

   logic [31:0] mem [FLASH_WORDS];
   fpp_prot_t   prot [NPB];
   fpp_prot_t   prot_nv [NPB];
   logic [31:0] user0, user1, user0_nv, user1_nv;
   logic [31:0] addr_reg, data_reg;
   logic [2:0]  prot_req;
   logic [15:0] clocks_per_usec;
   logic [1:0]  int_raw, int_en;
   logic        busy, fail;
   logic [31:0] cnt;
   logic [2:0]  op;
   fpp_state_t  state;

   // axi write capture
   logic        aw_hold, w_hold, do_wr;
   logic [31:0] aw_q, w_q;
   logic [3:0]  ws_q;
   logic [7:0]  wa;
   logic        wa_ok;
   assign s_axi_awready = !aw_hold && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold && !s_axi_bvalid;
   assign do_wr = aw_hold && w_hold && !s_axi_bvalid;
   assign wa    = aw_q[7:0];
   assign wa_ok = (aw_q[31:8] == 24'h0) && (wa <= REG_INT_MASK) && (wa[1:0] == 2'h0);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold <= 1'b0;
         w_hold  <= 1'b0;
         aw_q    <= 32'h0;
         w_q     <= 32'h0;
         ws_q    <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold <= 1'b1;
            aw_q    <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold <= 1'b1;
            w_q    <= s_axi_wdata;
            ws_q   <= s_axi_wstrb;
         end
         if (do_wr)
         begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wa_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   function automatic logic [31:0] merge(input logic [31:0] old);
      merge = old;
      for (int i = 0; i < 4; i++)
         if (ws_q[i])
            merge[i*8 +: 8] = w_q[i*8 +: 8];
   endfunction

   logic wr_cmd;
   assign wr_cmd = do_wr && wa_ok && (wa == REG_CMD) && ws_q[0];

   // target decode for a command
   logic [PA-1:0] pblk;
   logic          a_in, a_algn, cur_prot_ok, set_ok;
   fpp_prot_t     cur_p;
   assign a_in   = addr_reg < FLASH_BYTES;
   assign a_algn = addr_reg[1:0] == 2'h0;
   assign pblk   = PA'(addr_reg >> BA);
   assign cur_p  = a_in ? prot[pblk] : PROT_FULL;
   assign cur_prot_ok = (cur_p == PROT_FULL);
   assign set_ok = a_in && (prot_req <= 3'(PROT_FETCH)) && (prot_req[1:0] >= cur_p)
                   && !(cur_p == PROT_FETCH && prot_req[1:0] != PROT_FETCH);

   logic start_ok, refused;
   always_comb
   begin
      start_ok = 1'b0;
      refused  = 1'b0;
      if (wr_cmd && state == ST_IDLE)
         case (w_q[2:0])
            // unset clock rate is a programming error
            CMD_PROGRAM:
            begin
               start_ok = a_in && a_algn && cur_prot_ok && clocks_per_usec != 16'h0;
               refused  = !start_ok;
            end
            CMD_ERASE:
            begin
               start_ok = a_in && cur_prot_ok && clocks_per_usec != 16'h0;
               refused  = !start_ok;
            end
            CMD_PROT_SAVE, CMD_USER_SAVE: start_ok = 1'b1;
            CMD_PROT_SET: refused = !set_ok;
            default: refused = 1'b1;
         endcase
   end

   logic viol_cmd, viol_rd, finish;
   assign viol_cmd = wr_cmd && state == ST_IDLE && a_in && !cur_prot_ok
                     && (w_q[2:0] == CMD_PROGRAM || w_q[2:0] == CMD_ERASE);
   assign finish = (state == ST_RUN) && (cnt == 32'h0);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= ST_IDLE;
         cnt   <= 32'h0;
         op    <= 3'h0;
         fail  <= 1'b0;
      end
      else
         case (state)
            ST_IDLE:
            begin
               if (wr_cmd)
                  fail <= refused;
               if (start_ok)
               begin
                  state <= ST_RUN;
                  op    <= w_q[2:0];
                  case (w_q[2:0])
                     CMD_PROGRAM: cnt <= {16'h0, clocks_per_usec} * {16'h0, PROG_TIME_US};
                     CMD_ERASE:   cnt <= {16'h0, clocks_per_usec} * {16'h0, ERASE_TIME_US};
                     default:     cnt <= 32'h1;
                  endcase
               end
            end
            ST_RUN:
            begin
               if (cnt == 32'h0)
                  state <= ST_IDLE;
               else
                  cnt <= cnt - 32'h1;
            end
            default: state <= ST_IDLE;
         endcase
   end
   assign busy = (state == ST_RUN);

   // flash array is non-volatile: besides program and erase, only the factory init touches it
   always_ff @(posedge aclk)
   begin
      if (!nv_init_n)
      begin
         for (int i = 0; i < FLASH_WORDS; i++)
            mem[i] <= ERASED_WORD;
      end
      else if (finish && op == CMD_PROGRAM)
         mem[addr_reg[WA+1:2]] <= mem[addr_reg[WA+1:2]] & data_reg;
      else if (finish && op == CMD_ERASE)
      begin
         // whole 1 kB block to ones
         for (int i = 0; i < FLASH_WORDS; i++)
            if ((i * 4) >> EA == int'(addr_reg >> EA))
               mem[i] <= ERASED_WORD;
      end
   end

   // one setting per 2 kB block
   for (genvar b = 0; b < NPB; b++)
   begin : g_prot
      always_ff @(posedge aclk)
      begin
         if (!nv_init_n)
            prot_nv[b] <= PROT_FULL;
         else if (finish && op == CMD_PROT_SAVE)
            prot_nv[b] <= prot[b];
      end
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
            prot[b] <= prot_nv[b];
         else if (wr_cmd && state == ST_IDLE && w_q[2:0] == CMD_PROT_SET && set_ok && pblk == PA'(b))
            prot[b] <= fpp_prot_t'(prot_req[1:0]);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!nv_init_n)
      begin
         user0_nv <= USER_RST;
         user1_nv <= USER_RST;
      end
      else if (finish && op == CMD_USER_SAVE)
      begin
         user0_nv <= user0;
         user1_nv <= user1;
      end
   end

   // software registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         addr_reg <= 32'h0;
         data_reg <= ERASED_WORD;
         prot_req <= 3'h0;
         clocks_per_usec <= USEC_RST;
         user0 <= user0_nv;
         user1 <= user1_nv;
         int_en <= 2'h0;
      end
      else if (do_wr && wa_ok)
         case (wa)
            // address and data operands are frozen while an op runs
            REG_ADDR: if (!busy) addr_reg <= merge(addr_reg);
            REG_DATA: if (!busy) data_reg <= merge(data_reg);
            REG_PROT: prot_req <= 3'(merge({29'h0, prot_req}));
            REG_USEC: clocks_per_usec <= 16'(merge({16'h0, clocks_per_usec}));
            REG_USER0: user0 <= merge(user0);
            REG_USER1: user1 <= merge(user1);
            REG_INT_EN: int_en <= 2'(merge({30'h0, int_en}));
            default: ;
         endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         acc_rdata  <= 32'h0;
         acc_denied <= 1'b0;
      end
      else
      begin
         acc_denied <= viol_rd;
         acc_rdata  <= (acc_valid && !viol_rd && acc_addr < FLASH_BYTES) ? mem[acc_addr[WA+1:2]] : 32'h0;
      end
   end
   assign viol_rd = acc_valid && !acc_fetch && acc_addr < FLASH_BYTES
                    && prot[PA'(acc_addr >> BA)] == PROT_FETCH;

   logic [1:0] clr;
   assign clr = (do_wr && wa_ok && wa == REG_INT_RAW) ? w_q[1:0] & {2{ws_q[0]}} : 2'h0;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         int_raw <= 2'h0;
      else
      begin
         int_raw[INT_DONE_BIT] <= (int_raw[INT_DONE_BIT] && !clr[INT_DONE_BIT])
                                  || (finish && (op == CMD_PROGRAM || op == CMD_ERASE));
         int_raw[INT_VIOL_BIT] <= (int_raw[INT_VIOL_BIT] && !clr[INT_VIOL_BIT]) || viol_cmd || viol_rd;
      end
   end
   assign flash_irq = |(int_raw & int_en);

   // axi read
   logic [31:0] rd_mux;
   logic [7:0]  ra;
   assign ra = s_axi_araddr[7:0];
   assign s_axi_arready = !s_axi_rvalid;
   always_comb
   begin
      case (ra)
         REG_ADDR:     rd_mux = addr_reg;
         REG_DATA:     rd_mux = data_reg;
         REG_STATUS:   rd_mux = {30'h0, fail, busy};
         REG_PROT:     rd_mux = {30'h0, cur_p};
         REG_USEC:     rd_mux = {16'h0, clocks_per_usec};
         REG_USER0:    rd_mux = user0;
         REG_USER1:    rd_mux = user1;
         REG_INT_RAW:  rd_mux = {30'h0, int_raw};
         REG_INT_EN:   rd_mux = {30'h0, int_en};
         REG_INT_MASK: rd_mux = {30'h0, int_raw & int_en};
         default:      rd_mux = 32'h0;
      endcase
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= (s_axi_araddr[31:8] == 24'h0 && ra <= REG_INT_MASK && ra[1:0] == 2'h0)
                         ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   sequence s_prog_go;
      start_ok && w_q[2:0] == CMD_PROGRAM;
   endsequence
   property p_and_prog;
      finish && op == CMD_PROGRAM |=> (mem[addr_reg[WA+1:2]] & ~$past(mem[addr_reg[WA+1:2]])) == 32'h0;
   endproperty
   a_and_prog: assert property (@(posedge aclk) disable iff (!aresetn || !nv_init_n) p_and_prog)
      else $error("program raised a bit");
   property p_busy;
      s_prog_go |=> busy;
   endproperty
   a_busy: assert property (@(posedge aclk) disable iff (!aresetn) p_busy)
      else $error("busy missing after start");
   property p_nomod;
      wr_cmd && state == ST_IDLE && w_q[2:0] == CMD_ERASE && cur_p != PROT_FULL |=> fail && !busy;
   endproperty
   a_nomod: assert property (@(posedge aclk) disable iff (!aresetn) p_nomod)
      else $error("protected erase not refused");
   property p_fetch_deny;
      viol_rd |=> acc_denied && acc_rdata == 32'h0 && int_raw[INT_VIOL_BIT];
   endproperty
   a_fetch_deny: assert property (@(posedge aclk) disable iff (!aresetn) p_fetch_deny)
      else $error("fetch-only data read leaked");
   property p_frozen;
      prot[NPB-1] == PROT_FETCH |=> prot[NPB-1] == PROT_FETCH;
   endproperty
   a_frozen: assert property (@(posedge aclk) disable iff (!aresetn) p_frozen)
      else $error("fetch-only block loosened");
   property p_loosen_fail;
      wr_cmd && state == ST_IDLE && w_q[2:0] == CMD_PROT_SET && prot_req[1:0] < cur_p |=> fail;
   endproperty
   a_loosen_fail: assert property (@(posedge aclk) disable iff (!aresetn) p_loosen_fail)
      else $error("loosening not reported");
   property p_done_int;
      finish && op != CMD_PROT_SAVE && op != CMD_USER_SAVE |=> int_raw[INT_DONE_BIT] && !busy;
   endproperty
   a_done_int: assert property (@(posedge aclk) disable iff (!aresetn) p_done_int)
      else $error("done flag missing");
   property p_irq;
      do_wr && wa_ok && wa == REG_INT_EN && ws_q[0] |=> flash_irq == |(int_raw & $past(w_q[1:0]));
   endproperty
   a_irq: assert property (@(posedge aclk) disable iff (!aresetn) p_irq)
      else $error("irq does not follow the written enables");
   property p_prog_len;
      s_prog_go ##1 busy [*8] |-> cnt != 32'h0 || clocks_per_usec < 16'h1;
   endproperty
   a_prog_len: assert property (@(posedge aclk) disable iff (!aresetn) p_prog_len)
      else $error("program ended too soon");
endmodule

//--- hw/fpp_pkg.sv
/*
 * fpp_pkg: shared constants for the flash program and protect controller.
 * Assumes a 32-bit AXI4-Lite register bus and word-aligned registers.
 */
package fpp_pkg;
   localparam logic [7:0]  REG_ADDR      = 8'h00;
   localparam logic [7:0]  REG_DATA      = 8'h04;
   localparam logic [7:0]  REG_CMD       = 8'h08;
   localparam logic [7:0]  REG_STATUS    = 8'h0C;
   localparam logic [7:0]  REG_PROT      = 8'h10;
   localparam logic [7:0]  REG_USEC      = 8'h14;
   localparam logic [7:0]  REG_USER0     = 8'h18;
   localparam logic [7:0]  REG_USER1     = 8'h1C;
   localparam logic [7:0]  REG_INT_RAW   = 8'h20;
   localparam logic [7:0]  REG_INT_EN    = 8'h24;
   localparam logic [7:0]  REG_INT_MASK  = 8'h28;
   // command codes written to REG_CMD
   localparam logic [2:0]  CMD_PROGRAM   = 3'h1;
   localparam logic [2:0]  CMD_ERASE     = 3'h2;
   localparam logic [2:0]  CMD_PROT_SET  = 3'h3;
   localparam logic [2:0]  CMD_PROT_SAVE = 3'h4;
   localparam logic [2:0]  CMD_USER_SAVE = 3'h5;
   // status and interrupt bit positions
   localparam int          ST_BUSY_BIT   = 0;
   localparam int          ST_FAIL_BIT   = 1;
   localparam int          INT_DONE_BIT  = 0;
   localparam int          INT_VIOL_BIT  = 1;
   // reset values
   localparam logic [15:0] USEC_RST      = 16'h0000;
   localparam logic [31:0] USER_RST      = 32'hFFFFFFFF;
   localparam logic [31:0] ERASED_WORD   = 32'hFFFFFFFF;
   // operation times in microseconds
   localparam logic [15:0] PROG_TIME_US  = 16'h0014;
   localparam logic [15:0] ERASE_TIME_US = 16'h0064;
   localparam logic [15:0] SAVE_TIME_US  = 16'h0064;
   // geometry in bytes
   localparam int          ERASE_BYTES   = 1024;
   localparam int          PROT_BYTES    = 2048;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   typedef enum logic [1:0] {
      PROT_FULL  = 2'h0,   // prot_state_full_access
      PROT_NOMOD = 2'h1,   // prot_state_no_modify
      PROT_FETCH = 2'h2    // prot_state_fetch_only
   } fpp_prot_t;
   typedef enum {ST_IDLE, ST_RUN} fpp_state_t;
endpackage

//--- testbench/fpp_core_model.sv
/*
 * fpp_core_model: stands in for the core and debugger on the flash access port.
 * Assumes the controller answers one clock after each access is presented.
 */
module fpp_core_model
(
   input  wire logic        aclk,       // system clock
   output logic             acc_valid,  // access strobe
   output logic             acc_fetch,  // fetch or data read
   output logic [31:0]      acc_addr,   // byte address
   input  wire logic [31:0] acc_rdata,  // returned word
   input  wire logic        acc_denied  // refusal flag
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      acc_valid = 1'b0;
      acc_fetch = 1'b0;
      acc_addr  = 32'h00000000;
   end

   task automatic access(input logic f, input logic [31:0] a, output logic [31:0] d, output logic den);
      @(posedge aclk);
      acc_valid <= 1'b1;
      acc_fetch <= f;
      acc_addr  <= {a[31:2], 2'b00};
      @(posedge aclk);
      acc_valid <= 1'b0;
      // idle lines flip so a stale address never looks live
      acc_fetch <= ~f;
      acc_addr  <= ~a;
      @(negedge aclk);
      d   = acc_rdata;
      den = acc_denied;
   endtask
endmodule

//--- testbench/flash_program_protect_ctrl_bench.sv
/*
 * flash_program_protect_ctrl_bench: register-level tests of fpp_ctrl.
 * Assumes fpp_core_model issues the core fetches and data reads.
 */
module flash_program_protect_ctrl_bench
   import fpp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        aclk, aresetn, nv_init_n, acc_valid, acc_fetch, acc_denied, flash_irq, den;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, acc_addr, acc_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int          error_cnt, comparisons;

   fpp_ctrl #(.FLASH_WORDS(1024)) i_fpp_ctrl
   (
      .aclk(aclk), .aresetn(aresetn), .nv_init_n(nv_init_n),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .acc_valid(acc_valid),
      .acc_fetch(acc_fetch), .acc_addr(acc_addr), .acc_rdata(acc_rdata),
      .acc_denied(acc_denied), .flash_irq(flash_irq)
   );

   fpp_core_model i_fpp_core_model
   (
      .aclk(aclk), .acc_valid(acc_valid), .acc_fetch(acc_fetch), .acc_addr(acc_addr),
      .acc_rdata(acc_rdata), .acc_denied(acc_denied)
   );

   initial aclk = 1'b0;
   always #2.5 aclk = ~aclk;

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // ready is sampled mid-cycle, where it has settled, and acted on at the next edge
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_hit, w_hit, b_hit;
      b_hit = 1'b0;
      @(posedge aclk);
      s_axi_awaddr  <= {24'h000000, a};
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!b_hit)
      begin
         @(negedge aclk);
         aw_hit = s_axi_awvalid & s_axi_awready;
         w_hit  = s_axi_wvalid & s_axi_wready;
         b_hit  = s_axi_bvalid & s_axi_bready;
         r      = s_axi_bresp;
         @(posedge aclk);
         if (aw_hit) s_axi_awvalid <= 1'b0;
         if (w_hit) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_hit, r_hit;
      r_hit = 1'b0;
      @(posedge aclk);
      s_axi_araddr  <= {24'h000000, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (!r_hit)
      begin
         @(negedge aclk);
         ar_hit = s_axi_arvalid & s_axi_arready;
         r_hit  = s_axi_rvalid & s_axi_rready;
         d      = s_axi_rdata;
         r      = s_axi_rresp;
         @(posedge aclk);
         if (ar_hit) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      axi_write(a, d, rs);
   endtask

   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      axi_read(a, rd, rs);
      check(what, rd, exp);
   endtask

   task automatic idle(input string what, input logic exp_fail);
      int n;
      n = 0;
      do
      begin
         axi_read(REG_STATUS, rd, rs);
         n++;
      end
      while (rd[ST_BUSY_BIT] !== 1'b0 && n < 100);
      check(what, {30'h0, rd[ST_FAIL_BIT], rd[ST_BUSY_BIT]}, {30'h0, exp_fail, 1'b0});
   endtask

   task automatic cmd(input logic [2:0] c, input logic exp_fail, input string what);
      wr(REG_CMD, {29'h0, c});
      idle(what, exp_fail);
   endtask

   task automatic prog(input logic [31:0] a, input logic [31:0] d, input logic exp_fail);
      wr(REG_ADDR, a);
      wr(REG_DATA, d);
      cmd(CMD_PROGRAM, exp_fail, "program fail");
   endtask

   task automatic prot(input logic [31:0] a, input logic [1:0] code, input logic exp_fail);
      wr(REG_ADDR, a);
      wr(REG_PROT, {30'h0, code});
      cmd(CMD_PROT_SET, exp_fail, "prot fail");
   endtask

   task automatic achk(input logic f, input logic [31:0] a, input logic [31:0] exp, input logic exp_den);
      i_fpp_core_model.access(f, a, rd, den);
      check("acc data", rd, exp);
      check("acc denied", {31'h0, den}, {31'h0, exp_den});
   endtask

   task automatic irq_chk(input logic exp);
      @(negedge aclk);
      check("irq", {31'h0, flash_irq}, {31'h0, exp});
   endtask

   task automatic do_reset();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
   endtask

   initial
   begin
      #200000;
      error_cnt++;
      $display("watchdog expired");
      conclude();
   end

   initial
   begin
      {aresetn, nv_init_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      s_axi_wstrb = 4'hF;
      error_cnt = 0;
      comparisons = 0;
      repeat (20) @(posedge aclk);
      nv_init_n <= 1'b1;
      aresetn <= 1'b1;
      rchk("usec", REG_USEC, {16'h0000, USEC_RST});
      rchk("user0", REG_USER0, USER_RST);
      rchk("prot", REG_PROT, {30'h0, PROT_FULL});
      prog(32'h00000010, 32'h00000000, 1'b1);
      axi_write(8'h40, 32'h00000000, rs);
      check("unmapped", {30'h0, rs}, {30'h0, RESP_SLVERR});
      $display("test reset values done");
      wr(REG_USEC, 32'h00000001);
      check("bresp", {30'h0, rs}, {30'h0, RESP_OKAY});
      rchk("usec", REG_USEC, 32'h00000001);
      check("rresp", {30'h0, rs}, {30'h0, RESP_OKAY});
      axi_read(8'h40, rd, rs);
      check("rresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
      wr(REG_INT_RAW, 32'h00000003);
      prog(32'h00000010, 32'hF0F0FFFF, 1'b0);
      achk(1'b0, 32'h00000010, 32'hF0F0FFFF, 1'b0);
      prog(32'h00000010, 32'h0F0FFF00, 1'b0);
      achk(1'b0, 32'h00000010, 32'h0000FF00, 1'b0);
      prog(32'h00000400, 32'h00000000, 1'b0);
      rchk("int raw", REG_INT_RAW, 32'h00000001);
      wr(REG_INT_EN, 32'h00000001);
      irq_chk(1'b1);
      rchk("int mask", REG_INT_MASK, 32'h00000001);
      wr(REG_INT_EN, 32'h00000002);
      irq_chk(1'b0);
      wr(REG_INT_RAW, 32'h00000001);
      rchk("int raw", REG_INT_RAW, 32'h00000000);
      $display("test program and interrupts done");
      wr(REG_ADDR, 32'h00000010);
      cmd(CMD_ERASE, 1'b0, "erase fail");
      achk(1'b0, 32'h00000010, ERASED_WORD, 1'b0);
      achk(1'b1, 32'h000003FC, ERASED_WORD, 1'b0);
      achk(1'b0, 32'h00000400, 32'h00000000, 1'b0);
      wr(REG_ADDR, 32'h00000020);
      wr(REG_DATA, 32'h00000000);
      wr(REG_CMD, {29'h0, CMD_PROGRAM});
      wr(REG_ADDR, 32'h00000024);
      wr(REG_CMD, {29'h0, CMD_ERASE});
      idle("busy fail", 1'b0);
      achk(1'b0, 32'h00000020, 32'h00000000, 1'b0);
      rchk("addr", REG_ADDR, 32'h00000020);
      $display("test erase and busy done");
      wr(REG_INT_RAW, 32'h00000003);
      prot(32'h00000800, PROT_NOMOD, 1'b0);
      rchk("prot", REG_PROT, {30'h0, PROT_NOMOD});
      prog(32'h00000800, 32'h00000000, 1'b1);
      axi_read(REG_INT_RAW, rd, rs);
      check("viol", {31'h0, rd[INT_VIOL_BIT]}, 32'h00000001);
      cmd(CMD_ERASE, 1'b1, "erase fail");
      achk(1'b0, 32'h00000800, ERASED_WORD, 1'b0);
      prot(32'h00000800, PROT_FULL, 1'b1);
      rchk("prot", REG_PROT, {30'h0, PROT_NOMOD});
      prot(32'h00000800, 2'h3, 1'b1);
      prot(32'h00002000, PROT_NOMOD, 1'b1);
      prot(32'h00000800, PROT_FETCH, 1'b0);
      achk(1'b0, 32'h00000800, 32'h00000000, 1'b1);
      achk(1'b1, 32'h00000800, ERASED_WORD, 1'b0);
      prot(32'h00000800, PROT_NOMOD, 1'b1);
      rchk("prot", REG_PROT, {30'h0, PROT_FETCH});
      $display("test protection done");
      wr(REG_USER0, 32'h12345678);
      wr(REG_USER1, 32'h9ABCDEF0);
      rchk("user1", REG_USER1, 32'h9ABCDEF0);
      do_reset();
      rchk("user0", REG_USER0, USER_RST);
      wr(REG_ADDR, 32'h00000800);
      rchk("prot", REG_PROT, {30'h0, PROT_FULL});
      prot(32'h00000000, PROT_NOMOD, 1'b0);
      cmd(CMD_PROT_SAVE, 1'b0, "save fail");
      wr(REG_USER0, 32'hA5A5A5A5);
      cmd(CMD_USER_SAVE, 1'b0, "user save fail");
      do_reset();
      rchk("prot", REG_PROT, {30'h0, PROT_NOMOD});
      rchk("user0", REG_USER0, 32'hA5A5A5A5);
      achk(1'b0, 32'h00000400, 32'h00000000, 1'b0);
      $display("test commits done");
      conclude();
   end
endmodule
